//--- core/bts_pkg.sv
package bts_pkg;
  // time base: one millisecond of core_clk at 125 MHz
  localparam int unsigned CLK_KHZ   = 125000;
  localparam int unsigned MS_CYCLES = CLK_KHZ * 1;
  localparam logic [15:0] OVERHEAD_MS = 16'h0014;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BURST  = 8'h04;
  localparam logic [7:0] OFS_TMO    = 8'h08;
  localparam logic [7:0] OFS_DUP    = 8'h0C;
  localparam logic [7:0] OFS_HYST   = 8'h10;
  localparam logic [7:0] OFS_GAIN   = 8'h14;
  localparam logic [7:0] OFS_FRAME  = 8'h18;
  localparam logic [7:0] OFS_CMD    = 8'h1C;
  localparam logic [7:0] OFS_MISSED = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // control bit positions
  localparam int unsigned CB_FRAME = 0;
  localparam int unsigned CB_FALL  = 1;
  localparam int unsigned CB_LEVEL = 2;
  localparam int unsigned CB_SUPP  = 3;
  localparam int unsigned CB_SGOOD = 4;
  localparam int unsigned CB_HYST  = 5;
  // limits
  localparam logic [15:0] BURST_MAX = 16'h7530;
  localparam logic [15:0] BURST_INF = 16'h7531;
  localparam logic [15:0] TMO_MIN   = 16'h000A;
  localparam logic [15:0] TMO_MAX   = 16'h2710;
  localparam logic [15:0] DUP_MAX   = 16'h7530;
  localparam logic [15:0] SPC_MIN   = 16'h0014;
  localparam logic [15:0] SPC_MAX   = 16'h7530;
  localparam logic [3:0]  FRM_MIN   = 4'h2;
  localparam logic [3:0]  FRM_MAX   = 4'h9;
  localparam logic [15:0] CMD_STOP  = 16'h8400;
  // reset values
  localparam logic [15:0] RST_BURST = 16'h03E8;
  localparam logic [15:0] RST_TMO   = 16'h0064;
  localparam logic [15:0] RST_DUP   = 16'h0000;
  localparam logic [15:0] RST_SPC   = 16'h0064;
  localparam logic [3:0]  RST_FRM   = 4'h3;
  localparam logic [7:0]  RST_GAIN  = 8'h64;
  localparam logic [3:0]  RST_HCNT  = 4'h1;
  localparam logic [7:0]  RST_HWID  = 8'h05;

  typedef enum {ST_IDLE, ST_ATTEMPT, ST_GAP} bts_state_e;

  typedef struct packed {
    logic        frame_mode;
    logic        fall_edge;
    logic        level_trig;
    logic        supp_bad;
    logic        stop_good;
    logic        hyst_en;
    logic [15:0] burst_ms;
    logic [15:0] tmo_ms;
    logic [15:0] dup_ms;
    logic [3:0]  hyst_cnt;
    logic [7:0]  hyst_width;
    logic [7:0]  gain;
    logic [3:0]  frames;
    logic [15:0] spacing_ms;
  } bts_cfg_s;

  typedef struct packed {
    logic        done;
    logic        good;
    logic [31:0] code;
  } bts_dec_s;
endpackage : bts_pkg

//--- core/bts_sequencer.sv
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - interval mode: accepted trigger starts timed burst of capture plus decode
// - each interval attempt is followed by 20 ms overhead before next capture
// - triggers during any burst are ignored and counted as missed
// - burst length in ms, accepted range 0 to 30000
// - burst length 30001 means capture and decode forever
// - continuous burst ends on stop command 8400 or stop input pulse
// - decode abandoned after timeout, settable 10 to 10000 ms
// - stop-after-good ends finite interval bursts only
// - flag suppresses or emits the bad-read output
// - same result ignored for duplicate time, 0 to 30000 ms
// - hysteresis off, or 1 to 15 increments of set width
// - gains go preset, +k, -k times width for k up to count
// - good decode ends the hysteresis sequence
// - frame mode: up to N spaced captures, ends on good decode
// - frames per burst settable 2 to 9
// - frame spacing settable 20 to 30000 ms
// - decoder timeout counts as a bad read
// - trigger on rising edge, falling edge, or repeated while level held
module bts_sequencer
  import bts_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
)(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        trig_pin,
  input  wire logic        stop_pin,
  input  wire bts_dec_s    dec_in,
  output logic             cap_start,
  output logic      [7:0]  cap_gain,
  output logic             dec_abort,
  output logic             good_read,
  output logic             bad_read,
  output logic      [31:0] read_code,
  output logic             burst_active
);

  function automatic logic in_rng(input logic [15:0] v,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng

  function automatic logic [7:0] hyst_gain(input logic [7:0] pre,
                                           input logic [4:0] idx,
                                           input logic [7:0] wid);
    logic [3:0]         k;
    logic signed [13:0] g;
    k = 4'((idx + 5'h01) >> 1);
    if (idx[0])
      g = $signed({6'h00, pre}) + $signed({2'h0, 12'(k) * 12'(wid)});
    else
      g = $signed({6'h00, pre}) - $signed({2'h0, 12'(k) * 12'(wid)});
    if (g < 0)
      hyst_gain = 8'h00;
    else if (g > 14'sh00FF)
      hyst_gain = 8'hFF;
    else
      hyst_gain = g[7:0];
  endfunction : hyst_gain

  bts_cfg_s   cfg;
  bts_state_e state;
  logic [2:0]  trig_sync;
  logic [2:0]  stop_sync;
  logic        trig_lvl;
  logic        trig_lvl_d;
  logic        stop_lvl;
  logic        stop_lvl_d;
  logic [16:0] ms_cnt;
  logic        ms_tick;
  logic [15:0] burst_el;
  logic [15:0] att_ms;
  logic [15:0] gap_ms;
  logic [3:0]  frm_cnt;
  logic [4:0]  hyst_idx;
  logic        stop_pend;
  logic [15:0] missed;
  logic [15:0] dup_left;
  logic [31:0] last_code;
  logic        trig_edge;
  logic        trig_evt;
  logic        stop_evt;
  logic        cmd_stop;
  logic        timed_out;
  logic        att_end;
  logic        att_good;
  logic        inf_burst;
  logic        time_up;
  logic        end_burst;
  logic        gap_ready;
  logic        is_dup;
  logic [4:0]  hyst_last;

  // three-stage synchronisers; level changes once stages two and three agree
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      trig_sync  <= 3'h0;
      stop_sync  <= 3'h0;
      trig_lvl   <= 1'b0;
      trig_lvl_d <= 1'b0;
      stop_lvl   <= 1'b0;
      stop_lvl_d <= 1'b0;
    end
    else
    begin
      trig_sync  <= {trig_sync[1:0], trig_pin};
      stop_sync  <= {stop_sync[1:0], stop_pin};
      if (trig_sync[1] == trig_sync[2])
        trig_lvl <= trig_sync[2];
      if (stop_sync[1] == stop_sync[2])
        stop_lvl <= stop_sync[2];
      trig_lvl_d <= trig_lvl;
      stop_lvl_d <= stop_lvl;
    end

  always_comb
  begin
    trig_edge = cfg.fall_edge ? (trig_lvl_d & ~trig_lvl)
                              : (trig_lvl & ~trig_lvl_d);
    // level mode: retrigger whenever idle and level is held
    trig_evt  = cfg.level_trig ? (trig_lvl ^ cfg.fall_edge) : trig_edge;
    stop_evt  = stop_lvl & ~stop_lvl_d;
    cmd_stop  = reg_wr && reg_addr == OFS_CMD && reg_wdata[15:0] == CMD_STOP;
    inf_burst = cfg.burst_ms == BURST_INF;
    timed_out = att_ms >= cfg.tmo_ms && !dec_in.done;
    att_end   = state == ST_ATTEMPT && (dec_in.done || timed_out);
    att_good  = dec_in.done && dec_in.good;
    time_up   = !cfg.frame_mode && !inf_burst
                && burst_el >= cfg.burst_ms;
    end_burst = stop_pend || stop_evt || cmd_stop
                || (att_good && cfg.frame_mode)
                || (att_good && cfg.stop_good && !inf_burst)
                || (cfg.frame_mode && frm_cnt >= cfg.frames)
                || time_up;
    gap_ready = cfg.frame_mode ? gap_ms >= cfg.spacing_ms
                               : gap_ms >= OVERHEAD_MS;
    is_dup    = dup_left != 16'h0000 && dec_in.code == last_code;
    hyst_last = 5'({cfg.hyst_cnt, 1'b0});
    burst_active = state != ST_IDLE;
  end

  // millisecond time base
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      ms_cnt  <= 17'h00000;
      ms_tick <= 1'b0;
    end
    else
    begin
      ms_tick <= ms_cnt == 17'(MS_CYC - 1);
      ms_cnt  <= (ms_cnt == 17'(MS_CYC - 1)) ? 17'h00000 : ms_cnt + 17'h00001;
    end

  // burst sequencer
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      state     <= ST_IDLE;
      burst_el  <= 16'h0000;
      att_ms    <= 16'h0000;
      gap_ms    <= 16'h0000;
      frm_cnt   <= 4'h0;
      hyst_idx  <= 5'h00;
      stop_pend <= 1'b0;
      cap_start <= 1'b0;
      cap_gain  <= RST_GAIN;
      dec_abort <= 1'b0;
    end
    else
    begin
      cap_start <= 1'b0;
      dec_abort <= 1'b0;
      if (ms_tick && burst_el != 16'hFFFF)
        burst_el <= burst_el + 16'h0001;
      if (ms_tick && att_ms != 16'hFFFF)
        att_ms <= att_ms + 16'h0001;
      if (ms_tick && gap_ms != 16'hFFFF)
        gap_ms <= gap_ms + 16'h0001;
      if ((stop_evt || cmd_stop) && state != ST_IDLE)
        stop_pend <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          stop_pend <= 1'b0;
          if (trig_evt)
          begin
            state     <= ST_ATTEMPT;
            cap_start <= 1'b1;
            cap_gain  <= cfg.gain;
            burst_el  <= 16'h0000;
            att_ms    <= 16'h0000;
            gap_ms    <= 16'h0000;
            frm_cnt   <= 4'h1;
            hyst_idx  <= 5'h00;
          end
        end
        ST_ATTEMPT:
          if (att_end)
          begin
            dec_abort <= timed_out;
            if (att_good || !cfg.hyst_en || hyst_idx == hyst_last)
              hyst_idx <= 5'h00;
            else
              hyst_idx <= hyst_idx + 5'h01;
            if (!cfg.frame_mode)
              gap_ms <= 16'h0000;
            state <= end_burst ? ST_IDLE : ST_GAP;
          end
        ST_GAP:
          if (stop_pend || stop_evt || cmd_stop || time_up)
            state <= ST_IDLE;
          else if (gap_ready)
          begin
            state     <= ST_ATTEMPT;
            cap_start <= 1'b1;
            cap_gain  <= cfg.hyst_en && hyst_idx != 5'h00
                         ? hyst_gain(cfg.gain, hyst_idx,
                                     cfg.hyst_width)
                         : cfg.gain;
            att_ms    <= 16'h0000;
            gap_ms    <= 16'h0000;
            frm_cnt   <= frm_cnt + 4'h1;
          end
        default:
          state <= ST_IDLE;
      endcase
    end

  // result outputs and duplicate suppression
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      good_read <= 1'b0;
      bad_read  <= 1'b0;
      read_code <= 32'h00000000;
      last_code <= 32'h00000000;
      dup_left  <= 16'h0000;
    end
    else
    begin
      good_read <= 1'b0;
      bad_read  <= 1'b0;
      if (ms_tick && dup_left != 16'h0000)
        dup_left <= dup_left - 16'h0001;
      if (att_end && att_good && !is_dup)
      begin
        good_read <= 1'b1;
        read_code <= dec_in.code;
        last_code <= dec_in.code;
        dup_left  <= cfg.dup_ms;
      end
      if (att_end && !att_good)
        bad_read <= !cfg.supp_bad;
    end

  // register writes; out-of-range values are refused
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      cfg <= '{frame_mode: 1'b0, fall_edge: 1'b0, level_trig: 1'b0,
               supp_bad: 1'b0, stop_good: 1'b0, hyst_en: 1'b0,
               burst_ms: RST_BURST, tmo_ms: RST_TMO, dup_ms: RST_DUP,
               hyst_cnt: RST_HCNT, hyst_width: RST_HWID, gain: RST_GAIN,
               frames: RST_FRM, spacing_ms: RST_SPC};
    end
    else if (reg_wr)
      case (reg_addr)
        OFS_CTRL:
        begin
          cfg.frame_mode <= reg_wdata[CB_FRAME];
          cfg.fall_edge  <= reg_wdata[CB_FALL];
          cfg.level_trig <= reg_wdata[CB_LEVEL];
          cfg.supp_bad   <= reg_wdata[CB_SUPP];
          cfg.stop_good  <= reg_wdata[CB_SGOOD];
          cfg.hyst_en    <= reg_wdata[CB_HYST];
        end
        OFS_BURST:
          if (in_rng(reg_wdata[15:0], 16'h0000, BURST_INF))
            cfg.burst_ms <= reg_wdata[15:0];
        OFS_TMO:
          if (in_rng(reg_wdata[15:0], TMO_MIN, TMO_MAX))
            cfg.tmo_ms <= reg_wdata[15:0];
        OFS_DUP:
          if (in_rng(reg_wdata[15:0], 16'h0000, DUP_MAX))
            cfg.dup_ms <= reg_wdata[15:0];
        OFS_HYST:
          if (reg_wdata[3:0] != 4'h0)
          begin
            cfg.hyst_cnt   <= reg_wdata[3:0];
            cfg.hyst_width <= reg_wdata[15:8];
          end
        OFS_GAIN:
          cfg.gain <= reg_wdata[7:0];
        OFS_FRAME:
        begin
          if (in_rng({12'h000, reg_wdata[3:0]}, {12'h000, FRM_MIN},
                     {12'h000, FRM_MAX}))
            cfg.frames <= reg_wdata[3:0];
          if (in_rng(reg_wdata[31:16], SPC_MIN, SPC_MAX))
            cfg.spacing_ms <= reg_wdata[31:16];
        end
        default:
          cfg <= cfg;
      endcase

  // missed-trigger count; a miss in the clearing cycle survives
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      missed <= 16'h0000;
    else if (trig_edge && state != ST_IDLE)
      missed <= (reg_wr && reg_addr == OFS_MISSED) ? 16'h0001
                                                   : missed + 16'h0001;
    else if (reg_wr && reg_addr == OFS_MISSED)
      missed <= 16'h0000;

  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      case (reg_addr)
        OFS_CTRL:   reg_rdata <= {26'h0, cfg.hyst_en, cfg.stop_good,
                                  cfg.supp_bad, cfg.level_trig,
                                  cfg.fall_edge, cfg.frame_mode};
        OFS_BURST:  reg_rdata <= {16'h0, cfg.burst_ms};
        OFS_TMO:    reg_rdata <= {16'h0, cfg.tmo_ms};
        OFS_DUP:    reg_rdata <= {16'h0, cfg.dup_ms};
        OFS_HYST:   reg_rdata <= {16'h0, cfg.hyst_width, 4'h0, cfg.hyst_cnt};
        OFS_GAIN:   reg_rdata <= {24'h0, cfg.gain};
        OFS_FRAME:  reg_rdata <= {cfg.spacing_ms, 12'h0, cfg.frames};
        OFS_MISSED: reg_rdata <= {16'h0, missed};
        OFS_STATUS: reg_rdata <= {19'h0, hyst_idx, frm_cnt, 2'h0,
                                  stop_pend, burst_active};
        default:    reg_rdata <= 32'h00000000;
      endcase
    else
      reg_rdata <= 32'h00000000;

  chk_missed_count: assert property (@(posedge core_clk) disable iff (!arst_n)
    trig_edge && state != ST_IDLE && !reg_wr
    |=> missed == $past(missed) + 16'h0001)
    else $error("missed trigger not counted");
  chk_timeout_bad: assert property (@(posedge core_clk) disable iff (!arst_n)
    state == ST_ATTEMPT && timed_out
    |=> dec_abort && bad_read == !cfg.supp_bad)
    else $error("timeout not handled as bad read");
  chk_no_start_busy: assert property (@(posedge core_clk) disable iff (!arst_n)
    state == ST_ATTEMPT |=> !cap_start || $past(state) != ST_ATTEMPT)
    else $error("capture started mid attempt");
  chk_frame_good: assert property (@(posedge core_clk) disable iff (!arst_n)
    att_end && att_good && cfg.frame_mode |=> state == ST_IDLE)
    else $error("frame burst did not end on good read");
  chk_inf_runs: assert property (@(posedge core_clk) disable iff (!arst_n)
    att_end && !cfg.frame_mode && inf_burst && !stop_pend && !stop_evt
    && !cmd_stop |=> state == ST_GAP)
    else $error("continuous burst ended without stop");
  chk_burst_done: assert property (@(posedge core_clk) disable iff (!arst_n)
    state == ST_GAP && time_up |=> state == ST_IDLE)
    else $error("finite burst overran its length");
  chk_plain_gain: assert property (@(posedge core_clk) disable iff (!arst_n)
    cap_start && !cfg.hyst_en && !$past(reg_wr) |-> cap_gain == cfg.gain)
    else $error("gain differs from preset");
  chk_tmo_range: assert property (@(posedge core_clk) disable iff (!arst_n)
    cfg.tmo_ms >= TMO_MIN && cfg.tmo_ms <= TMO_MAX)
    else $error("decoder timeout out of range");

endmodule : bts_sequencer

//--- test/bts_dec_model.sv
`timescale 1ns/1ns
module bts_dec_model
  import bts_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        cap_start,
  input  wire logic        dec_abort,
  input  wire logic        resp_en,
  input  wire logic        resp_good,
  input  wire logic [15:0] resp_dly,
  input  wire logic [31:0] resp_code,
  output bts_dec_s         dec_in
);
  logic        busy;
  logic [15:0] cnt;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy   <= 1'b0;
      cnt    <= 16'h0000;
      dec_in <= '0;
    end
    else
    begin
      // result lines toggle while no answer is presented
      dec_in <= {1'b0, ~dec_in.good, ~dec_in.code};
      if (cap_start)
      begin
        busy <= 1'b1;
        cnt  <= resp_dly;
      end
      else if (dec_abort)
        busy <= 1'b0;
      else if (busy && resp_en)
      begin
        if (cnt == 16'h0000)
        begin
          busy   <= 1'b0;
          dec_in <= {1'b1, resp_good, resp_code};
        end
        else
          cnt <= cnt - 16'h0001;
      end
    end
  end
endmodule : bts_dec_model

//--- test/bts_sequencer_tb.sv
`timescale 1ns/1ns
module bts_sequencer_tb
  import bts_pkg::*;
;
  localparam int MS = 10;
  logic        core_clk  = 1'b0;
  logic        arst_n    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        trig_pin  = 1'b0;
  logic        stop_pin  = 1'b0;
  logic        resp_en   = 1'b1;
  logic        resp_good = 1'b0;
  logic [15:0] resp_dly  = 16'h0005;
  logic [31:0] resp_code = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] read_code;
  logic [31:0] rd;
  logic [7:0]  cap_gain;
  logic        cap_start;
  logic        dec_abort;
  logic        good_read;
  logic        bad_read;
  logic        burst_active;
  bts_dec_s    dec_in;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          n_cap      = 0;
  int          n_good     = 0;
  int          n_bad      = 0;
  int          c;

  bts_sequencer #(.MS_CYC(MS)) u_bts_sequencer (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_pin(trig_pin), .stop_pin(stop_pin),
    .dec_in(dec_in), .cap_start(cap_start), .cap_gain(cap_gain),
    .dec_abort(dec_abort), .good_read(good_read), .bad_read(bad_read),
    .read_code(read_code), .burst_active(burst_active));

  bts_dec_model u_bts_dec_model (
    .core_clk(core_clk), .arst_n(arst_n), .cap_start(cap_start),
    .dec_abort(dec_abort), .resp_en(resp_en), .resp_good(resp_good),
    .resp_dly(resp_dly), .resp_code(resp_code), .dec_in(dec_in));

  always #4 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    if (cap_start === 1'b1) n_cap++;
    if (good_read === 1'b1) n_good++;
    if (bad_read === 1'b1) n_bad++;
  end

  task final_report;
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rdr

  // 0: capture pulse, 1: burst idle, 2: abort pulse
  task automatic wait_for(input int w, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 5000)
    begin
      @(posedge core_clk);
      n++;
      hit = (w == 0) ? cap_start === 1'b1 :
            (w == 1) ? burst_active === 1'b0 : dec_abort === 1'b1;
    end
    if (!hit)
      check(32'h0, 32'h1);
  endtask : wait_for

  task trig_capture;
    @(posedge core_clk);
    trig_pin <= 1'b1;
    wait_for(0, c);
    trig_pin <= 1'b0;
  endtask : trig_capture

  function automatic logic [7:0] exp_gain(input int p, w, i);
    int g;
    g = (i % 2) ? p + ((i + 1) / 2) * w : p - ((i + 1) / 2) * w;
    g = (g < 0) ? 0 : (g > 255) ? 255 : g;
    return g[7:0];
  endfunction : exp_gain

  task t_regs;
    rdr(OFS_BURST, rd); check(rd, {16'h0, RST_BURST});
    rdr(OFS_TMO, rd); check(rd, {16'h0, RST_TMO});
    rdr(OFS_HYST, rd); check(rd, {16'h0, RST_HWID, 4'h0, RST_HCNT});
    rdr(8'h3C, rd); check(rd, 32'h0);
    wr(OFS_BURST, 32'h7532); rdr(OFS_BURST, rd); check(rd, {16'h0, RST_BURST});
    wr(OFS_BURST, {16'h0, BURST_MAX}); rdr(OFS_BURST, rd); check(rd, {16'h0, BURST_MAX});
    wr(OFS_TMO, 32'h9); rdr(OFS_TMO, rd); check(rd, {16'h0, RST_TMO});
    wr(OFS_TMO, {16'h0, TMO_MAX}); rdr(OFS_TMO, rd); check(rd, {16'h0, TMO_MAX});
    wr(OFS_TMO, {16'h0, RST_TMO});
    wr(OFS_FRAME, 32'h0064_000A); rdr(OFS_FRAME, rd); check(rd, {RST_SPC, 12'h0, RST_FRM});
    wr(OFS_FRAME, 32'h0013_0009); rdr(OFS_FRAME, rd); check(rd, {RST_SPC, 12'h0, FRM_MAX});
    wr(OFS_HYST, 32'h0500); rdr(OFS_HYST, rd); check(rd, {16'h0, RST_HWID, 4'h0, RST_HCNT});
  endtask : t_regs

  task t_hyst(input logic [7:0] p, input logic [7:0] w, input logic [3:0] k,
              input logic use_pin);
    wr(OFS_CTRL, 32'h20);
    wr(OFS_BURST, {16'h0, BURST_INF});
    wr(OFS_GAIN, {24'h0, p});
    wr(OFS_HYST, {16'h0, w, 4'h0, k});
    wr(OFS_MISSED, 32'h0);
    resp_good <= 1'b0;
    n_bad = 0;
    trig_capture();
    check(cap_gain, p);
    for (int i = 1; i < 2 * k + 1; i++)
    begin
      wait_for(0, c);
      // a second trigger edge lands in mid-burst
      if (i == 1) trig_pin <= 1'b1;
      if (i == 2) trig_pin <= 1'b0;
      check(cap_gain, exp_gain(p, w, i));
    end
    check(n_bad, 2 * k);
    rdr(OFS_MISSED, rd); check(rd, 32'h1);
    rdr(OFS_STATUS, rd); check(rd[0], 1'b1);
    @(posedge core_clk);
    if (use_pin) stop_pin <= 1'b1;
    if (!use_pin) wr(OFS_CMD, {16'h0, CMD_STOP});
    repeat (10) @(posedge core_clk);
    stop_pin <= 1'b0;
    wait_for(1, c); check(burst_active, 1'b0);
    rdr(OFS_STATUS, rd); check(rd[1:0], 2'h0);
  endtask : t_hyst

  task t_finite;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_BURST, 32'd100);
    wr(OFS_TMO, 32'd10);
    n_cap = 0;
    trig_capture();
    wait_for(1, c);
    check(c >= 97 * MS && c <= 106 * MS, 1'b1);
    check(n_cap >= 100 / (20 + 10), 1'b1);
  endtask : t_finite

  task t_good;
    resp_good <= 1'b1;
    resp_code <= 32'h0000_00A5;
    wr(OFS_DUP, 32'd100);
    wr(OFS_CTRL, 32'h30);
    wr(OFS_HYST, 32'h0502);
    wr(OFS_GAIN, {24'h0, RST_GAIN});
    n_cap = 0;
    n_good = 0;
    trig_capture();
    wait_for(1, c);
    check(c < 20 * MS, 1'b1);
    check(n_cap, 1);
    check(read_code, 32'h0000_00A5);
    resp_code <= 32'h0000_005A;
    wr(OFS_BURST, {16'h0, BURST_INF});
    n_good = 0;
    trig_capture();
    wait_for(0, c); check(cap_gain, 8'h64);
    wait_for(0, c); check(cap_gain, 8'h64);
    check(n_good, 1);
    check(read_code, 32'h0000_005A);
    wr(OFS_CMD, {16'h0, CMD_STOP});
    wait_for(1, c); check(burst_active, 1'b0);
    wr(OFS_DUP, 32'h0);
  endtask : t_good

  task t_timeout(input logic supp);
    resp_en <= 1'b0;
    wr(OFS_CTRL, {28'h0, supp, 3'h0});
    wr(OFS_BURST, 32'h0);
    n_bad = 0;
    trig_capture();
    wait_for(2, c);
    check(c >= 9 * MS && c <= 11 * MS + 2, 1'b1);
    check(bad_read, !supp);
    wait_for(1, c); check(n_bad, supp ? 0 : 1);
    resp_en <= 1'b1;
  endtask : t_timeout

  task t_frame;
    resp_good <= 1'b0;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_FRAME, 32'h0014_0002);
    n_cap = 0;
    trig_capture();
    wait_for(0, c);
    check(c >= 19 * MS && c <= 21 * MS, 1'b1);
    wait_for(1, c); check(n_cap, 2);
    wr(OFS_FRAME, 32'h0014_0009);
    resp_good <= 1'b1;
    resp_code <= 32'h0000_0077;
    n_cap = 0;
    trig_capture();
    wait_for(1, c); check(n_cap, 1);
    check(read_code, 32'h0000_0077);
  endtask : t_frame

  task t_trig_modes;
    wr(OFS_CTRL, 32'h2);
    wr(OFS_BURST, 32'h0);
    n_cap = 0;
    trig_pin <= 1'b1;
    repeat (20) @(posedge core_clk);
    check(n_cap, 0);
    trig_pin <= 1'b0;
    wait_for(0, c); check(c < 10, 1'b1);
    wait_for(1, c);
    wr(OFS_CTRL, 32'h4);
    n_cap = 0;
    trig_pin <= 1'b1;
    repeat (100) @(posedge core_clk);
    trig_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    wait_for(1, c); check(n_cap > 3, 1'b1);
  endtask : t_trig_modes

  initial
  begin
    repeat (10) @(posedge core_clk);
    check(cap_gain, RST_GAIN);
    arst_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_regs();
    t_hyst(8'h64, 8'h05, 4'h2, 1'b0);
    t_hyst(8'h32, 8'h14, 4'h4, 1'b1);
    t_finite();
    t_good();
    t_timeout(1'b0);
    t_timeout(1'b1);
    t_frame();
    t_trig_modes();
    final_report();
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    final_report();
  end
endmodule : bts_sequencer_tb
